// ==== rtl/fine_gain_trim_regs.sv ====
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
// What this block does
// RULE_01 - eight byte-wide trim registers sit at indexes 0x360 to 0x367 and all are read-write.
// RULE_02 - bits 4:0 of each register hold the 5-bit fine gain and read zero after reset.
// RULE_03 - software writes zero into the reserved bits 7:5 of every trim register.
// RULE_04 - converter 2 uses the 0x362 value on input a and the 0x363 value on input b.
// RULE_05 - converter 3 uses the 0x364 value on input c and the 0x365 value on input d.
// RULE_06 - converters 0, 1, 4 and 5 use 0x360, 0x361, 0x366 and 0x367 whatever the input.
// RULE_07 - default register contents are loaded from the factory fuse store.
// RULE_08 - a written value reaches its converter path after the write and reads back as stored.
module fine_gain_trim_regs #(
    parameter int ADR_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic conv2_in_b_i,
    input wire logic conv3_in_d_i,
    output logic [29:0] path_gain_o,
    output logic fuse_req_o,
    output logic [2:0] fuse_addr_o,
    input wire logic fuse_ack_i,
    input wire logic [4:0] fuse_data_i
);
    localparam int IW = ADR_W - 2;
    localparam int NR = trim_pkg::NUM_REGS;
    localparam int FW = trim_pkg::FIELD_W;

    if (ADR_W < 12 || ADR_W > 32) begin : g_bad_adr
        $error("fine_gain_trim_regs: ADR_W must be 12 to 32");
    end

    fuse_if fuse_link ();

    logic [7:0] trim_val [NR];
    logic [NR-1:0] trim_hit;
    logic [NR-1:0] trim_wr;
    logic ack;
    logic [31:0] rd_data;
    logic load_done;
    logic rsvd_seen;
    logic [29:0] next_path_gain;

    // bus decode: word index is the byte address over four
    wire [IW-1:0] adr_word = wb_adr_i[ADR_W-1:2];
    wire bus_req = wb_cyc_i && wb_stb_i;
    wire loading = fuse_link.busy;
    // new requests wait while fuses load so a write is never overwritten
    wire take_req = bus_req && !ack && !loading;
    wire commit = ack && bus_req;
    wire commit_wr = commit && wb_we_i;
    wire lane0 = wb_sel_i[0];
    wire status_hit = adr_word == IW'(trim_pkg::IDX_STATUS);
    wire any_trim_hit = |trim_hit;
    wire [2:0] trim_num = 3'(adr_word - IW'(trim_pkg::IDX_CONV0));
    wire [7:0] trim_rd = trim_val[trim_num];
    wire rsvd_nonzero = wb_dat_i[trim_pkg::RSVD_MSB:trim_pkg::RSVD_LSB] != 3'h0;
    wire status_wr = commit_wr && status_hit && lane0;
    wire reload_req = status_wr && wb_dat_i[trim_pkg::CTRL_RELOAD_BIT];
    wire rsvd_clr = status_wr && wb_dat_i[trim_pkg::CTRL_RSVD_CLR_BIT];
    wire rsvd_set = commit_wr && any_trim_hit && lane0 && rsvd_nonzero;
    wire last_load = fuse_link.load && fuse_link.load_idx == 3'(NR - 1);

    wire [31:0] status_word = {27'h0, conv3_in_d_i, conv2_in_b_i, rsvd_seen,
        loading, load_done};
    wire [31:0] read_mux = any_trim_hit ? {24'h0, trim_rd} :
        status_hit ? status_word : 32'h0000_0000;

    // fuse store port
    assign fuse_req_o = fuse_link.req;
    assign fuse_addr_o = fuse_link.addr;
    assign fuse_link.ack = fuse_ack_i;
    assign fuse_link.data = fuse_data_i;

    fuse_loader #(
        .NUM_WORDS(NR)
    ) u_loader (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(reload_req),
        .fuse(fuse_link.loader)
    );

    for (genvar i = 0; i < NR; i++) begin : g_trim
        assign trim_hit[i] = adr_word == IW'(trim_pkg::TRIM_IDX[i]); // RULE_01
        assign trim_wr[i] = commit_wr && trim_hit[i] && lane0; // RULE_08

        trim_reg #(
            .RESET_VAL(trim_pkg::TRIM_RESET)
        ) u_reg (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_i(trim_wr[i]),
            .wr_data_i(wb_dat_i[7:0]),
            .load_i(fuse_link.load && fuse_link.load_idx == 3'(i)),
            .load_data_i(fuse_link.load_data),
            .value_o(trim_val[i])
        );
    end

    // path selection; an input change lands on the next edge, a write on the second edge after it commits
    wire [FW-1:0] field_c0 = trim_val[0][trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB];
    wire [FW-1:0] field_c1 = trim_val[1][trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB];
    wire [FW-1:0] field_c2a = trim_val[2][trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB];
    wire [FW-1:0] field_c2b = trim_val[3][trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB];
    wire [FW-1:0] field_c3c = trim_val[4][trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB];
    wire [FW-1:0] field_c3d = trim_val[5][trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB];
    wire [FW-1:0] field_c4 = trim_val[6][trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB];
    wire [FW-1:0] field_c5 = trim_val[7][trim_pkg::FIELD_MSB:trim_pkg::FIELD_LSB];
    wire [FW-1:0] conv2_gain = conv2_in_b_i ? field_c2b : field_c2a; // RULE_04
    wire [FW-1:0] conv3_gain = conv3_in_d_i ? field_c3d : field_c3c; // RULE_05

    assign next_path_gain = {field_c5, field_c4, conv3_gain, conv2_gain,
        field_c1, field_c0}; // RULE_06

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            path_gain_o <= 30'h0000_0000; // RULE_02
        end else begin
            path_gain_o <= next_path_gain; // RULE_08
        end
    end

    // single wait state; ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= take_req;
        end
    end

    assign wb_ack_o = ack;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data <= 32'h0000_0000;
        end else if (take_req) begin
            rd_data <= read_mux; // RULE_01
        end
    end

    assign wb_dat_o = rd_data;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_done <= 1'b0;
        end else if (last_load) begin
            load_done <= 1'b1;
        end else if (reload_req) begin
            load_done <= 1'b0;
        end
    end

    // software slip detector; hardware set beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsvd_seen <= 1'b0;
        end else if (rsvd_set) begin
            rsvd_seen <= 1'b1; // RULE_03
        end else if (rsvd_clr) begin
            rsvd_seen <= 1'b0;
        end
    end

    // checks on the path outputs
    conv2_select_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
        1'b1 |=> path_gain_o[14:10] == ($past(conv2_in_b_i) ?
            $past(trim_val[3][4:0]) : $past(trim_val[2][4:0])))
        else $error("converter 2 gain from wrong register");

    conv3_select_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        1'b1 |=> path_gain_o[19:15] == ($past(conv3_in_d_i) ?
            $past(trim_val[5][4:0]) : $past(trim_val[4][4:0])))
        else $error("converter 3 gain from wrong register");

    fixed_paths_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
        1'b1 |=> path_gain_o[4:0] == $past(trim_val[0][4:0])
            && path_gain_o[9:5] == $past(trim_val[1][4:0])
            && path_gain_o[24:20] == $past(trim_val[6][4:0])
            && path_gain_o[29:25] == $past(trim_val[7][4:0]))
        else $error("fixed converter gain from wrong register");

    write_reach_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        commit_wr && trim_hit[0] && lane0 |=> ##1 path_gain_o[4:0] == $past(wb_dat_i[4:0], 2))
        else $error("written gain did not reach path 0");

    path_reset_a: assert property (@(posedge clk_i) // RULE_02
        $past(rst_i) |-> path_gain_o == 30'h0000_0000)
        else $error("path gains not zero after reset");

    // checks on the bus answer, the fuse load start and the reserved-bit flag
    read_back_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        ack && !wb_we_i && any_trim_hit |-> wb_dat_o == {24'h0, trim_rd})
        else $error("trim read does not match register");

    unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack && !wb_we_i && !any_trim_hit && !status_hit |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack |=> !ack)
        else $error("ack held longer than one cycle");

    ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !ack && !loading |=> ack)
        else $error("request not answered in one cycle");

    load_stall_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        loading && !ack |=> !ack)
        else $error("bus answered during fuse load");

    fuse_first_a: assert property (@(posedge clk_i) // RULE_07
        $past(rst_i) |-> fuse_req_o && fuse_addr_o == 3'h0)
        else $error("fuse load not started after reset");

    rsvd_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        rsvd_set |=> rsvd_seen)
        else $error("reserved write not flagged");
endmodule

// ==== rtl/trim_pkg.sv ====
package trim_pkg;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_REGS = 8;
    localparam int NUM_PATHS = 6;
    localparam int FUSE_AW = 3;
    localparam int FIELD_LSB = 0;
    localparam int FIELD_MSB = 4;
    localparam int FIELD_W = 5;
    localparam int RSVD_LSB = 5;
    localparam int RSVD_MSB = 7;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic [9:0] IDX_CONV0 = 10'h360;
    localparam logic [9:0] IDX_CONV1 = 10'h361;
    localparam logic [9:0] IDX_CONV2_IN_A = 10'h362;
    localparam logic [9:0] IDX_CONV2_IN_B = 10'h363;
    localparam logic [9:0] IDX_CONV3_IN_C = 10'h364;
    localparam logic [9:0] IDX_CONV3_IN_D = 10'h365;
    localparam logic [9:0] IDX_CONV4 = 10'h366;
    localparam logic [9:0] IDX_CONV5 = 10'h367;
    localparam logic [9:0] IDX_STATUS = 10'h368;
    localparam logic [9:0] TRIM_IDX [NUM_REGS] = '{IDX_CONV0, IDX_CONV1,
        IDX_CONV2_IN_A, IDX_CONV2_IN_B, IDX_CONV3_IN_C, IDX_CONV3_IN_D,
        IDX_CONV4, IDX_CONV5};
    localparam int ST_DONE_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_RSVD_BIT = 2;
    localparam int ST_SEL2_BIT = 3;
    localparam int ST_SEL3_BIT = 4;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int CTRL_RSVD_CLR_BIT = 2;
endpackage

// ==== rtl/fuse_if.sv ====
`timescale 1ns/1ns
interface fuse_if;
    logic req;
    logic ack;
    logic [2:0] addr;
    logic [4:0] data;
    logic load;
    logic [2:0] load_idx;
    logic [4:0] load_data;
    logic busy;
    modport loader (
        output req, addr, load, load_idx, load_data, busy,
        input ack, data
    );
    modport host (
        input req, addr, load, load_idx, load_data, busy,
        output ack, data
    );
endinterface

// ==== rtl/trim_reg.sv ====
`timescale 1ns/1ns
module trim_reg #(
    parameter logic [7:0] RESET_VAL = trim_pkg::TRIM_RESET
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic load_i,
    input wire logic [4:0] load_data_i,
    output logic [7:0] value_o
);
    wire [7:0] load_word = {3'h0, load_data_i};

    // fuse load wins; bus is stalled while loading anyway
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_o <= RESET_VAL; // RULE_02
        end else if (load_i) begin
            value_o <= load_word; // RULE_07
        end else if (wr_i) begin
            value_o <= wr_data_i; // RULE_08
        end
    end

    reset_zero_a: assert property (@(posedge clk_i) $past(rst_i) |-> value_o[4:0] == 5'h00) // RULE_02
        else $error("trim field not zero after reset");
    write_store_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
        wr_i && !load_i |=> value_o == $past(wr_data_i))
        else $error("written trim value not stored");
    fuse_store_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        load_i |=> value_o == {3'h0, $past(load_data_i)})
        else $error("fuse value not stored");
endmodule

// ==== rtl/fuse_loader.sv ====
`timescale 1ns/1ns
module fuse_loader #(
    parameter int NUM_WORDS = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    fuse_if.loader fuse
);
    typedef enum logic [0:0] {LD_IDLE, LD_FETCH} ld_state_e;

    ld_state_e state;
    ld_state_e next_state;
    logic [2:0] idx;
    logic [2:0] next_idx;

    if (NUM_WORDS < 1 || NUM_WORDS > 2 ** trim_pkg::FUSE_AW) begin : g_bad_words
        $error("fuse_loader: NUM_WORDS out of range");
    end

    wire fetching = state == LD_FETCH;
    wire last = idx == 3'(NUM_WORDS - 1);
    wire take = fetching && fuse.ack;

    assign fuse.req = fetching;
    assign fuse.addr = idx;
    assign fuse.load = take; // RULE_07
    assign fuse.load_idx = idx;
    assign fuse.load_data = fuse.data;
    assign fuse.busy = fetching;

    always_comb begin
        next_state = state;
        next_idx = idx;
        unique case (state)
            LD_IDLE: begin
                if (start_i) begin
                    next_state = LD_FETCH;
                    next_idx = 3'h0;
                end
            end
            LD_FETCH: begin
                if (take) begin
                    next_idx = 3'(idx + 3'h1);
                    if (last) begin
                        next_state = LD_IDLE;
                    end
                end
            end
        endcase
    end

    // reset enters fetch so defaults come from fuses without software help
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= LD_FETCH; // RULE_07
            idx <= 3'h0;
        end else begin
            state <= next_state;
            idx <= next_idx;
        end
    end

    fetch_order_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        take && !last |=> fuse.req && fuse.addr == 3'($past(idx) + 3'h1))
        else $error("fuse words not fetched in order");
    load_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
        take && last |=> !fuse.busy)
        else $error("loader busy after last word");
endmodule

// ==== testbench/fine_gain_trim_regs_tb.sv ====
`timescale 1ns/1ns
module fine_gain_trim_regs_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic conv2_in_b_i = 1'b0;
    logic conv3_in_d_i = 1'b0;
    logic [29:0] path_gain_o;
    logic fuse_req_o;
    logic [2:0] fuse_addr_o;
    logic fuse_ack_i = 1'b0;
    logic [4:0] fuse_data_i = 5'h00;
    logic fuse_en = 1'b0;
    int fuse_cnt = 0;
    int error_cnt = 0;
    int n_tests = 0;
    logic [7:0] wv [8];

    fine_gain_trim_regs #(.ADR_W(12)) i_fine_gain_trim_regs (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv2_in_b_i(conv2_in_b_i),
        .conv3_in_d_i(conv3_in_d_i), .path_gain_o(path_gain_o), .fuse_req_o(fuse_req_o),
        .fuse_addr_o(fuse_addr_o), .fuse_ack_i(fuse_ack_i), .fuse_data_i(fuse_data_i)
    );

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [4:0] fuse_word(input logic [2:0] n);
        return 5'h11 + {2'b00, n};
    endfunction

    // fuse store stand-in: answers every other cycle, scrambles data when idle
    always @(posedge clk_i) begin
        fuse_ack_i <= fuse_en & fuse_req_o & ~fuse_ack_i;
        fuse_data_i <= (fuse_en & fuse_req_o & ~fuse_ack_i) ? fuse_word(fuse_addr_o) : ~fuse_data_i;
        if (fuse_req_o === 1'b1 && fuse_ack_i === 1'b1) begin
            chk("fuse_addr", 32'(fuse_cnt % 8), {29'h0000_0000, fuse_addr_o});
            fuse_cnt <= fuse_cnt + 1;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [7:0] wd,
                           output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h00_0000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 500);
        if (n >= 500) chk("wb_ack", 32'h0000_0001, 32'h0000_0000);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // stale data must not matter once the strobe is gone
        wb_dat_i <= ~wb_dat_i;
        @(posedge clk_i);
    endtask

    function automatic logic [11:0] reg_adr(input int n);
        return 12'hd80 + 12'(4 * n);
    endfunction

    // reset shows zero gains, then the fuse words become the register contents
    task automatic test_reset_and_fuse();
        logic [31:0] rd;
        repeat (3) begin
            @(posedge clk_i);
            chk("path_gain_reset", 32'h0000_0000, {2'b00, path_gain_o});
        end
        fuse_en <= 1'b1;
        // read issued while the load still runs must wait and see the loaded word
        wb_xfer(1'b0, reg_adr(7), 8'h00, rd);
        chk("fuse_words", 32'h0000_0008, 32'(fuse_cnt));
        chk("reg7_fuse", {27'h000_0000, fuse_word(3'd7)}, rd);
        for (int i = 0; i < 7; i++) begin
            wb_xfer(1'b0, reg_adr(i), 8'h00, rd);
            chk("reg_fuse", {27'h000_0000, fuse_word(3'(i))}, rd);
        end
        repeat (2) @(posedge clk_i);
        chk("path_fuse", {2'b00, fuse_word(3'd7), fuse_word(3'd6), fuse_word(3'd4),
            fuse_word(3'd2), fuse_word(3'd1), fuse_word(3'd0)}, {2'b00, path_gain_o});
    endtask

    task automatic test_rw_all();
        logic [31:0] rd;
        for (int i = 0; i < 8; i++) begin
            wv[i] = {3'b000, 5'h08 + 5'(3 * i)};
            // upper bits kept at zero on every write
            wb_xfer(1'b1, reg_adr(i), wv[i], rd);
        end
        for (int i = 7; i >= 0; i--) begin
            wb_xfer(1'b0, reg_adr(i), 8'h00, rd);
            chk("reg_readback", {24'h00_0000, wv[i]}, rd);
        end
        wb_xfer(1'b1, 12'hda4, 8'h1f, rd);
        wb_xfer(1'b0, 12'hda4, 8'h00, rd);
        chk("unmapped_read", 32'h0000_0000, rd);
        wb_xfer(1'b0, reg_adr(0), 8'h00, rd);
        chk("reg0_after_unmapped", {24'h00_0000, wv[0]}, rd);
    endtask

    // every select combination picks the right pair member; other paths never move
    task automatic test_select();
        logic [29:0] exp;
        for (int s = 0; s < 4; s++) begin
            conv2_in_b_i <= s[0];
            conv3_in_d_i <= s[1];
            repeat (3) @(posedge clk_i);
            exp = {wv[7][4:0], wv[6][4:0], s[1] ? wv[5][4:0] : wv[4][4:0],
                   s[0] ? wv[3][4:0] : wv[2][4:0], wv[1][4:0], wv[0][4:0]};
            chk("path_gain_sel", {2'b00, exp}, {2'b00, path_gain_o});
        end
    endtask

    // a fresh write reaches the selected path without waiting for a select change
    task automatic test_live_update();
        logic [31:0] rd;
        wb_xfer(1'b1, reg_adr(5), 8'h1f, rd);
        repeat (2) @(posedge clk_i);
        chk("path_conv3_d", 32'h0000_001f, {27'h000_0000, path_gain_o[19:15]});
        wb_xfer(1'b1, reg_adr(3), 8'h00, rd);
        repeat (2) @(posedge clk_i);
        chk("path_conv2_b", 32'h0000_0000, {27'h000_0000, path_gain_o[14:10]});
    endtask

    // a reload command refills every register; both selects are high here
    task automatic test_reload();
        logic [31:0] rd;
        wb_xfer(1'b0, reg_adr(8), 8'h00, rd);
        chk("status_idle", 32'h0000_0019, rd);
        wb_xfer(1'b1, reg_adr(8), 8'h01, rd);
        wb_xfer(1'b0, reg_adr(5), 8'h00, rd);
        chk("fuse_reload_cnt", 32'h0000_0010, 32'(fuse_cnt));
        chk("reg5_reload", {27'h000_0000, fuse_word(3'd5)}, rd);
        wb_xfer(1'b0, reg_adr(8), 8'h00, rd);
        chk("status_done", 32'h0000_0019, rd);
        repeat (2) @(posedge clk_i);
        chk("path_reload", {2'b00, fuse_word(3'd7), fuse_word(3'd6), fuse_word(3'd5),
            fuse_word(3'd3), fuse_word(3'd1), fuse_word(3'd0)}, {2'b00, path_gain_o});
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // whole run needs well under 1000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset_and_fuse();
        test_rw_all();
        test_select();
        test_live_update();
        test_reload();
        end_of_test();
    end
endmodule
